/* File: common/dbgtg_pkg.sv */
`default_nettype none
// ============================================================
// shared constants for the thread group control block
package dbgtg_pkg;
    localparam int DBGTG_THREADS = 6;
    localparam int DBGTG_AW = 4;
    // register byte offsets
    localparam logic [DBGTG_AW-1:0] DBGTG_OFS_EXT = 4'h0;
    localparam logic [DBGTG_AW-1:0] DBGTG_OFS_BRK = 4'h4;
    localparam logic [DBGTG_AW-1:0] DBGTG_OFS_STAT = 4'h8;
    // field positions (low bit of each six-bit field)
    localparam int DBGTG_EXT_RESUME_LSB = 16;
    localparam int DBGTG_EXT_BREAK_LSB = 8;
    localparam int DBGTG_HWBP1_LSB = 24;
    localparam int DBGTG_HWBP0_LSB = 16;
    localparam int DBGTG_SWBP_LSB = 8;
    // value of every select field after reset
    localparam logic [5:0] DBGTG_FIELD_RST = 6'h3F;
    // answer for an unmapped read
    localparam logic [31:0] DBGTG_UNMAPPED = 32'h0000_0000;
endpackage : dbgtg_pkg
`default_nettype wire

/* File: logic/dbgtg_ctrl.sv */
`default_nettype none
module dbgtg_ctrl
    import dbgtg_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [DBGTG_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // trigger pulses
    input wire logic ext_resume_i,
    input wire logic ext_break_i,
    input wire logic hwbp0_hit_i,
    input wire logic hwbp1_hit_i,
    input wire logic swbp_hit_i,
    // per-thread commands to the core
    output logic [DBGTG_THREADS-1:0] thread_halt_o,
    output logic [DBGTG_THREADS-1:0] thread_resume_o
);

    // ============================================================
    // register map, byte offsets
    //   0x0 external select
    //       21:16 threads released by an external resume
    //       13:8  threads halted by an external break
    //   0x4 breakpoint select
    //       29:24 threads halted by breakpoint one
    //       21:16 threads halted by breakpoint zero
    //       13:8  threads halted by a software breakpoint
    //   0x8 status, read only
    //       5:0   threads now in debug
    //   fields are six bits, thread zero at the low bit
    //   other offsets read as zero and drop writes
    //   byte lane zero holds no field and is ignored
    // bus timing
    //   a request is taken while no answer is pending; waitrequest
    //   then drops for exactly one cycle, so every access has one
    //   wait state and back to back requests are safe
    // trigger timing
    //   a trigger high at an edge gives a one-cycle command pulse
    //   from that same edge; a thread halted and resumed together
    //   stays halted

    // ============================================================
    // state
    // thread masks hold one bit per thread, thread zero at bit 0
    typedef struct packed {
        logic [DBGTG_THREADS-1:0] ext_resume_sel;
        logic [DBGTG_THREADS-1:0] ext_break_sel;
        logic [DBGTG_THREADS-1:0] hwbp1_sel;
        logic [DBGTG_THREADS-1:0] hwbp0_sel;
        logic [DBGTG_THREADS-1:0] swbp_sel;
        logic [DBGTG_THREADS-1:0] in_debug;
        logic [DBGTG_THREADS-1:0] halt;
        logic [DBGTG_THREADS-1:0] resume;
        logic waitreq;
        logic [31:0] rdata;
    } dbgtg_state_t;

    dbgtg_state_t state_q;
    dbgtg_state_t state_d;

    // ============================================================
    // next state
    always_comb
    begin
        logic [DBGTG_THREADS-1:0] halt_set;
        logic [DBGTG_THREADS-1:0] res_set;
        logic access;
        logic wr_go;
        logic rd_go;
        logic sel_ext;
        logic sel_brk;
        logic sel_stat;
        halt_set = '0;
        res_set = '0;
        state_d = state_q;
        // a request is taken only while no answer is pending
        access = (avs_read_i || avs_write_i) && state_q.waitreq;
        wr_go = access && avs_write_i;
        rd_go = access && avs_read_i;
        // word decode, any other offset is unmapped
        sel_ext = (avs_address_i == DBGTG_OFS_EXT);
        sel_brk = (avs_address_i == DBGTG_OFS_BRK);
        sel_stat = (avs_address_i == DBGTG_OFS_STAT);
        // each trigger masks its own field, several combine by union
        if (ext_break_i)
        begin
            halt_set = halt_set | state_q.ext_break_sel;
        end
        if (hwbp1_hit_i)
        begin
            halt_set = halt_set | state_q.hwbp1_sel;
        end
        if (hwbp0_hit_i)
        begin
            halt_set = halt_set | state_q.hwbp0_sel;
        end
        if (swbp_hit_i)
        begin
            halt_set = halt_set | state_q.swbp_sel;
        end
        // resume reaches only the threads of its own field
        if (ext_resume_i)
        begin
            res_set = state_q.ext_resume_sel;
        end
        state_d.halt = halt_set;
        // a halt in the same cycle wins over resume for that thread
        state_d.resume = res_set & ~halt_set;
        // status: set by halt, cleared by resume, halt wins
        state_d.in_debug = (state_q.in_debug & ~res_set) | halt_set;
        // answer one cycle after the request is taken, for one cycle
        state_d.waitreq = !access;
        // lane one carries the two fields at bits 13:8
        if (wr_go && avs_byteenable_i[1])
        begin
            if (sel_ext)
            begin
                state_d.ext_break_sel = avs_writedata_i[
                    DBGTG_EXT_BREAK_LSB +: DBGTG_THREADS];
            end
            else if (sel_brk)
            begin
                state_d.swbp_sel = avs_writedata_i[
                    DBGTG_SWBP_LSB +: DBGTG_THREADS];
            end
        end
        // lane two carries the two fields at bits 21:16
        if (wr_go && avs_byteenable_i[2])
        begin
            if (sel_ext)
            begin
                state_d.ext_resume_sel = avs_writedata_i[
                    DBGTG_EXT_RESUME_LSB +: DBGTG_THREADS];
            end
            else if (sel_brk)
            begin
                state_d.hwbp0_sel = avs_writedata_i[
                    DBGTG_HWBP0_LSB +: DBGTG_THREADS];
            end
        end
        // lane three carries only breakpoint one at bits 29:24
        if (wr_go && avs_byteenable_i[3] && sel_brk)
        begin
            state_d.hwbp1_sel = avs_writedata_i[
                DBGTG_HWBP1_LSB +: DBGTG_THREADS];
        end
        // read data, unused bits zero, held until the next read
        if (rd_go)
        begin
            state_d.rdata = DBGTG_UNMAPPED;
            if (sel_ext)
            begin
                state_d.rdata[DBGTG_EXT_RESUME_LSB +: DBGTG_THREADS] =
                    state_q.ext_resume_sel;
                state_d.rdata[DBGTG_EXT_BREAK_LSB +: DBGTG_THREADS] =
                    state_q.ext_break_sel;
            end
            else if (sel_brk)
            begin
                state_d.rdata[DBGTG_HWBP1_LSB +: DBGTG_THREADS] =
                    state_q.hwbp1_sel;
                state_d.rdata[DBGTG_HWBP0_LSB +: DBGTG_THREADS] =
                    state_q.hwbp0_sel;
                state_d.rdata[DBGTG_SWBP_LSB +: DBGTG_THREADS] =
                    state_q.swbp_sel;
            end
            else if (sel_stat)
            begin
                state_d.rdata[DBGTG_THREADS-1:0] = state_q.in_debug;
            end
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            // every field selects all threads after reset
            state_q.ext_resume_sel <= DBGTG_FIELD_RST;
            state_q.ext_break_sel <= DBGTG_FIELD_RST;
            state_q.hwbp1_sel <= DBGTG_FIELD_RST;
            state_q.hwbp0_sel <= DBGTG_FIELD_RST;
            state_q.swbp_sel <= DBGTG_FIELD_RST;
            // no thread in debug, no command, no answer pending
            state_q.in_debug <= '0;
            state_q.halt <= '0;
            state_q.resume <= '0;
            state_q.waitreq <= 1'b1;
            state_q.rdata <= DBGTG_UNMAPPED;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ============================================================
    // outputs, each straight from a flop
    // read data of the last read
    assign avs_readdata_o = state_q.rdata;
    // wait while no answer is due, idle included
    assign avs_waitrequest_o = state_q.waitreq;
    // one-cycle command pulses to the core
    assign thread_halt_o = state_q.halt;
    assign thread_resume_o = state_q.resume;

endmodule : dbgtg_ctrl
`default_nettype wire

/* File: verif/dbgtg_chk.sv */
`default_nettype none
// ==========================================
// port checker for the thread group block
module dbgtg_chk
    import dbgtg_pkg::*;
(
    // clock, reset and bus
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [DBGTG_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // triggers and thread commands
    input wire logic ext_resume_i,
    input wire logic ext_break_i,
    input wire logic hwbp0_hit_i,
    input wire logic hwbp1_hit_i,
    input wire logic swbp_hit_i,
    input wire logic [DBGTG_THREADS-1:0] thread_halt_o,
    input wire logic [DBGTG_THREADS-1:0] thread_resume_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // a halt pulse always has a halting trigger behind it
    property p_halt_cause;
        thread_halt_o != '0 |->
            $past(ext_break_i | hwbp0_hit_i | hwbp1_hit_i | swbp_hit_i);
    endproperty
    a_halt_cause: assert property (p_halt_cause)
        else $error("stray halt");
    property p_halt_idle;
        !(ext_break_i | hwbp0_hit_i | hwbp1_hit_i | swbp_hit_i)
            |=> thread_halt_o == '0;
    endproperty
    a_halt_idle: assert property (p_halt_idle)
        else $error("halt w/o cause");
    property p_res_cause;
        thread_resume_o != '0 |-> $past(ext_resume_i);
    endproperty
    a_res_cause: assert property (p_res_cause)
        else $error("stray resume");
    // halt wins over resume per thread
    property p_disjoint;
        (thread_halt_o & thread_resume_o) == '0;
    endproperty
    a_disjoint: assert property (p_disjoint)
        else $error("halt and resume");
    // bus answers one cycle after taking a request, for one cycle
    property p_wait_ans;
        (avs_read_i | avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
    property p_wait_one;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("long answer");
    property p_unmapped;
        avs_read_i && avs_waitrequest_o && avs_address_i == 4'hC
            |=> avs_readdata_o == DBGTG_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
    property p_rd_hold;
        !avs_read_i |=> $stable(avs_readdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : dbgtg_chk
bind dbgtg_ctrl dbgtg_chk u_dbgtg_chk (.clock_i, .rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
    .ext_resume_i, .ext_break_i, .hwbp0_hit_i, .hwbp1_hit_i, .swbp_hit_i,
    .thread_halt_o, .thread_resume_o);
`default_nettype wire

/* File: verif/dbgtg_probe.sv */
`default_nettype none
// ==========================================
// debug probe raising one-cycle trigger pulses
module dbgtg_probe (
    // clock in, triggers out
    input wire logic clock_i,
    output logic [4:0] trig_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial trig_o = 5'h00;
    // bits: resume, break, hwbp0, hwbp1, swbp
    task automatic pulse(input logic [4:0] t);
        @(posedge clock_i);
        trig_o <= t;
        @(posedge clock_i);
        trig_o <= 5'h00;
    endtask : pulse
endmodule : dbgtg_probe
`default_nettype wire

/* File: verif/tb.sv */
`default_nettype none
// ==========================================
// thread group bench
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic rd = 1'b0, wr = 1'b0, wq;
    logic [3:0] ad = 4'h0;
    logic [3:0] bel = 4'hF;
    logic [31:0] wd = 32'h0000_0000, q, rdat;
    logic [4:0] tg;
    logic [5:0] h, r;
    int fail_count = 0, n_tests = 0;
    always #4 clock_i = ~clock_i;
    dbgtg_probe u_dbgtg_probe (.clock_i, .trig_o(tg));
    dbgtg_ctrl u_dbgtg_ctrl (.clock_i, .rst_i, .avs_address_i(ad),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(bel), .avs_readdata_o(q), .avs_waitrequest_o(wq),
        .ext_resume_i(tg[0]), .ext_break_i(tg[1]), .hwbp0_hit_i(tg[2]),
        .hwbp1_hit_i(tg[3]), .swbp_hit_i(tg[4]), .thread_halt_o(h),
        .thread_resume_o(r));
    task automatic wrap_up;
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // one bus access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clock_i);
        wr <= w;
        rd <= !w;
        ad <= a;
        wd <= d;
        do @(posedge clock_i); while (wq !== 1'b0);
        rdat = q;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : acc
    task automatic fire(input logic [4:0] t, input logic [5:0] eh, er);
        u_dbgtg_probe.pulse(t);
        #1;
        chk({20'h0_0000, h, r}, {20'h0_0000, eh, er});
    endtask : fire
    task automatic s_default;
        acc(1'b0, 4'h0, 32'h0000_0000);
        chk(rdat & 32'h003F_3F00, 32'h003F_3F00);
        acc(1'b0, 4'h4, 32'h0000_0000);
        chk(rdat & 32'h3F3F_3F00, 32'h3F3F_3F00);
        for (int i = 0; i < 5; i++)
            fire(5'(1 << i), i ? 6'h3F : 6'h00, i ? 6'h00 : 6'h3F);
    endtask : s_default
    task automatic s_fields;
        acc(1'b1, 4'h0, 32'h002A_1500);
        acc(1'b1, 4'h4, 32'h0120_0C00);
        acc(1'b0, 4'h4, 32'h0000_0000);
        chk(rdat & 32'h3F3F_3F00, 32'h0120_0C00);
        fire(5'h01, 6'h00, 6'h2A);
        fire(5'h02, 6'h15, 6'h00);
        fire(5'h04, 6'h20, 6'h00);
        fire(5'h08, 6'h01, 6'h00);
        fire(5'h10, 6'h0C, 6'h00);
        fire(5'h1C, 6'h2D, 6'h00);
        fire(5'h03, 6'h15, 6'h2A);
        acc(1'b1, 4'hC, 32'hFFFF_FFFF);
        acc(1'b0, 4'hC, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
    endtask : s_fields
    // status register, halt beating resume, byte lanes, read-only word
    task automatic s_status;
        acc(1'b1, 4'h0, 32'h003F_0100);
        fire(5'h01, 6'h00, 6'h3F);
        acc(1'b0, 4'h8, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        fire(5'h03, 6'h01, 6'h3E);
        acc(1'b1, 4'h8, 32'hFFFF_FFFF);
        acc(1'b0, 4'h8, 32'h0000_0000);
        chk(rdat, 32'h0000_0001);
        bel <= 4'h4;
        acc(1'b1, 4'h0, 32'h0015_3F00);
        bel <= 4'hF;
        acc(1'b0, 4'h0, 32'h0000_0000);
        chk(rdat, 32'h0015_0100);
    endtask : s_status
    initial
    begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        s_default();
        s_fields();
        s_status();
        wrap_up();
    end
    initial
    begin
        #20000;
        fail_count++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
